// ==== hw/dbgx_cfg.svh ====
/*
  Constants for the debug-state exit and program-counter tracking block.
  Assumes a 32-bit instruction word and word-aligned instruction addresses.
*/
// Behaviour
// R1 - Penultimate instruction break high, branch low.
// R2 - Debugger selects resume after loading branch.
// R3 - Resume only when test machine enters idle.
// R4 - Indicator high throughout debug state.
// R5 - Flush pipeline on debug entry.
// R6 - Fetches stop and restart one cycle late.
// R7 - Indicator drops during system-speed access.
// R8 - Force input holds indicator high.
// R9 - Breakpoint adds four, each instruction one.
// R10 - Debugger runs two instructions before branch.
// R11 - Chain shifts most significant bit first.
// R12 - Watchpoint adds four, each instruction one.
// R13 - Watchpoint with exception waits for vector.
// R14 - Watchpoint with exception adds three.
// R15 - Debug request adds three, each instruction one.
// R16 - System-speed access adds three addresses.
// R17 - Aborted system access sets abort mode.
// R18 - Cause from break bit and entry bit.
// R19 - Debugger reads cause before other accesses.
// R20 - Debugger may return with subtract instead; the code only exits on a branch, and a subtract goes to system-speed access.
// R21 - Debugger return offset four plus counts.
// R22 - Debugger return offset three plus counts.
// R23 - Break bit only on memory instructions.
`ifndef DBGX_CFG_SVH
`define DBGX_CFG_SVH

`define DBGX_CHAIN_LEN 33
`define DBGX_BREAK_POS 32
`define DBGX_ADDR_SHIFT 2
`define DBGX_ADV_BKPT 32'h00000004
`define DBGX_ADV_REQ 32'h00000003
`define DBGX_ADV_SYSACC 32'h00000003
`define DBGX_ADV_INSN 32'h00000001
`define DBGX_PC_RESET 32'h00000000
`define DBGX_IR_LEN 4
`define DBGX_IR_INTEST 4'hc
`define DBGX_IR_RESTART 4'h4
`define DBGX_IR_BYPASS 4'hf
`define DBGX_IR_CAPTURE 4'h1
`define DBGX_BR_HI 27
`define DBGX_BR_LO 25
`define DBGX_BR_OPC 3'h5
`define DBGX_BR_OFF_HI 23

`endif

// ==== hw/dbgx_pkg.sv ====
/*
  Types for the debug-state exit block.
  Assumes the constants header is on the include path.
*/
`include "dbgx_cfg.svh"
package dbgx_pkg;
    typedef enum logic [6:0] {
        DBGX_RUN = 7'h01,
        DBGX_WAITEXC = 7'h02,
        DBGX_HALTED = 7'h04,
        DBGX_ARMED = 7'h08,
        DBGX_SYSPEND = 7'h10,
        DBGX_SYSACC = 7'h20,
        DBGX_EXITING = 7'h40
    } dbgx_core_t;

    typedef enum logic [15:0] {
        DBGX_TLR = 16'h0001, DBGX_RTI = 16'h0002, DBGX_SELDR = 16'h0004,
        DBGX_CAPDR = 16'h0008, DBGX_SHDR = 16'h0010, DBGX_EX1DR = 16'h0020,
        DBGX_PSDR = 16'h0040, DBGX_EX2DR = 16'h0080, DBGX_UPDR = 16'h0100,
        DBGX_SELIR = 16'h0200, DBGX_CAPIR = 16'h0400, DBGX_SHIR = 16'h0800,
        DBGX_EX1IR = 16'h1000, DBGX_PSIR = 16'h2000, DBGX_EX2IR = 16'h4000,
        DBGX_UPIR = 16'h8000
    } dbgx_tap_t;

    typedef struct packed {
        dbgx_core_t state;
        logic [31:0] pc;
        logic [31:0] word;
        logic ind;
        logic ind_out;
        logic run_d1;
        logic fetch;
        logic flush;
        logic sysclk;
        logic abort;
        logic brk;
        logic moe;
        logic [2:0] ins_sync;
        logic [2:0] rst_sync;
        logic [1:0] req_sync;
    } dbgx_sys_t;

    typedef struct packed {
        dbgx_tap_t tap;
        logic [`DBGX_IR_LEN-1:0] ir;
        logic [`DBGX_IR_LEN-1:0] ir_sr;
        logic [`DBGX_CHAIN_LEN-1:0] sr;
        logic [`DBGX_CHAIN_LEN-1:0] upd;
        logic ins_tgl;
        logic rst_tgl;
        logic sysmode;
        logic [1:0] brk_sync;
        logic tdo;
    } dbgx_tck_t;
endpackage

// ==== hw/dbgx_core.sv ====
/*
  Debug-state entry, exit and program-counter tracking, with a test access
  port and scan chain 1 on the test clock.
  Assumes the test clock is unrelated to ref_clk_i and that the debugger
  follows the documented exit sequence.
*/
`timescale 1ns/1ps
`include "dbgx_cfg.svh"
module dbgx_core
    import dbgx_pkg::*;
(
    // System clock and reset.
    input wire logic ref_clk_i,
    input wire logic srst_i,
    // Test port, on its own clock.
    input wire logic tck_i,
    input wire logic link_rst_i,
    input wire logic tms_i,
    input wire logic tdi_i,
    output logic tdo_o,
    // Core events, on the system clock.
    input wire logic [31:0] core_pc_i,
    input wire logic external_halt_request_i,
    input wire logic breakpoint_hit_i,
    input wire logic watchpoint_hit_i,
    input wire logic exception_i,
    input wire logic exception_done_i,
    input wire logic sys_access_done_i,
    input wire logic sys_access_abort_i,
    input wire logic force_indicator_i,
    // Status toward the system.
    output logic debug_state_indicator_o,
    output logic system_clock_qualifier_o,
    output logic mem_fetch_o,
    output logic pipeline_flush_o,
    output logic abort_mode_o,
    output logic scan_break_flag_o,
    output logic method_of_entry_bit_o,
    output logic [31:0] pc_o
);

    // ========================================================
    // System-clock domain
    // ========================================================
    dbgx_sys_t s_reg;
    dbgx_sys_t s_next;
    dbgx_tck_t t_reg;
    dbgx_tck_t t_next;
    logic ins_evt;
    logic rst_evt;
    logic req_s;
    logic is_branch;
    logic [31:0] br_off;

    assign ins_evt = s_reg.ins_sync[2] ^ s_reg.ins_sync[1];
    assign rst_evt = s_reg.rst_sync[2] ^ s_reg.rst_sync[1];
    assign req_s = s_reg.req_sync[1];
    assign is_branch = (t_reg.upd[`DBGX_BR_HI:`DBGX_BR_LO] == `DBGX_BR_OPC);
    assign br_off = {{6{s_reg.word[`DBGX_BR_OFF_HI]}},
                     s_reg.word[`DBGX_BR_OFF_HI:0], 2'h0};

    always_comb begin
        s_next = s_reg;
        s_next.ins_sync = {s_reg.ins_sync[1:0], t_reg.ins_tgl};
        s_next.rst_sync = {s_reg.rst_sync[1:0], t_reg.rst_tgl};
        s_next.req_sync = {s_reg.req_sync[0], external_halt_request_i};
        s_next.flush = 1'b0;
        case (s_reg.state)
            DBGX_RUN: begin
                s_next.pc = core_pc_i;
                if (req_s) begin
                    s_next.pc = core_pc_i + (`DBGX_ADV_REQ << `DBGX_ADDR_SHIFT); // [R15]
                    s_next.moe = 1'b1; // [R18]
                    s_next.brk = 1'b0;
                    s_next.state = DBGX_HALTED;
                    s_next.flush = 1'b1; // [R5]
                end else if (breakpoint_hit_i) begin
                    s_next.pc = core_pc_i + (`DBGX_ADV_BKPT << `DBGX_ADDR_SHIFT); // [R9]
                    s_next.moe = 1'b0; // [R18]
                    s_next.brk = 1'b0;
                    s_next.state = DBGX_HALTED;
                    s_next.flush = 1'b1; // [R5]
                end else if (watchpoint_hit_i && exception_i) begin
                    s_next.state = DBGX_WAITEXC; // [R13]
                end else if (watchpoint_hit_i) begin
                    s_next.pc = core_pc_i + (`DBGX_ADV_BKPT << `DBGX_ADDR_SHIFT); // [R12]
                    s_next.moe = 1'b0; // [R18]
                    s_next.brk = 1'b1;
                    s_next.state = DBGX_HALTED;
                    s_next.flush = 1'b1; // [R5]
                end
            end
            DBGX_WAITEXC: begin
                // Entry is held until the exception mode change and vector fetch.
                s_next.pc = core_pc_i;
                if (exception_done_i) begin // [R13]
                    s_next.pc = core_pc_i + (`DBGX_ADV_REQ << `DBGX_ADDR_SHIFT); // [R14]
                    s_next.moe = 1'b0;
                    s_next.brk = 1'b1;
                    s_next.abort = sys_access_abort_i;
                    s_next.state = DBGX_HALTED;
                    s_next.flush = 1'b1; // [R5]
                end
            end
            DBGX_HALTED: begin
                if (ins_evt) begin
                    s_next.word = t_reg.upd[31:0];
                    s_next.pc = s_reg.pc + (`DBGX_ADV_INSN << `DBGX_ADDR_SHIFT); // [R9]
                    if (t_reg.upd[`DBGX_BREAK_POS]) begin // [R11]
                        s_next.state = DBGX_ARMED;
                    end
                end
            end
            DBGX_ARMED: begin
                if (ins_evt) begin
                    s_next.word = t_reg.upd[31:0];
                    if (is_branch && !t_reg.upd[`DBGX_BREAK_POS]) begin // [R1]
                        s_next.pc = s_reg.pc + (`DBGX_ADV_INSN << `DBGX_ADDR_SHIFT);
                        s_next.state = DBGX_EXITING;
                    end else begin
                        s_next.state = DBGX_SYSPEND;
                    end
                end
            end
            DBGX_SYSPEND: begin
                if (rst_evt) begin // [R2]
                    s_next.state = DBGX_SYSACC;
                end
            end
            DBGX_SYSACC: begin
                if (sys_access_done_i || sys_access_abort_i) begin
                    s_next.pc = s_reg.pc + (`DBGX_ADV_SYSACC << `DBGX_ADDR_SHIFT); // [R16]
                    s_next.brk = 1'b1; // [R18]
                    s_next.abort = s_reg.abort | sys_access_abort_i; // [R17]
                    s_next.state = DBGX_HALTED;
                end
            end
            DBGX_EXITING: begin
                // The resume waits for the test machine so that several cores
                // sharing the port leave debug together.
                if (rst_evt) begin // [R3]
                    s_next.pc = s_reg.pc + br_off;
                    s_next.abort = 1'b0;
                    s_next.state = DBGX_RUN;
                end
            end
            default: begin
                s_next.state = DBGX_RUN;
            end
        endcase
        s_next.ind = (s_next.state != DBGX_RUN) && (s_next.state != DBGX_WAITEXC)
                     && (s_next.state != DBGX_SYSACC); // [R4] [R7]
        s_next.ind_out = s_next.ind | force_indicator_i; // [R8]
        s_next.sysclk = !s_next.ind;
        s_next.run_d1 = !s_reg.ind;
        s_next.fetch = !s_reg.ind | s_reg.run_d1; // [R6]
    end

    always_ff @(posedge ref_clk_i) begin
        if (srst_i) begin
            s_reg <= '{state: DBGX_RUN, pc: `DBGX_PC_RESET, word: 32'h00000000,
                       ind: 1'b0, ind_out: 1'b0, run_d1: 1'b1, fetch: 1'b1,
                       flush: 1'b0, sysclk: 1'b1, abort: 1'b0, brk: 1'b0,
                       moe: 1'b0, ins_sync: 3'h0, rst_sync: 3'h0,
                       req_sync: 2'h0};
        end else begin
            s_reg <= s_next;
        end
    end

    assign debug_state_indicator_o = s_reg.ind_out;
    assign system_clock_qualifier_o = s_reg.sysclk;
    assign mem_fetch_o = s_reg.fetch;
    assign pipeline_flush_o = s_reg.flush;
    assign abort_mode_o = s_reg.abort;
    assign scan_break_flag_o = s_reg.brk;
    assign method_of_entry_bit_o = s_reg.moe;
    assign pc_o = s_reg.pc;

    // ========================================================
    // Test-clock domain
    // ========================================================
    // The instruction word is held in upd until the next update, so the
    // system side may read it once the toggle has crossed.
    always_comb begin
        t_next = t_reg;
        t_next.brk_sync = {t_reg.brk_sync[0], s_reg.brk};
        case (t_reg.tap)
            DBGX_TLR: t_next.tap = tms_i ? DBGX_TLR : DBGX_RTI;
            DBGX_RTI: t_next.tap = tms_i ? DBGX_SELDR : DBGX_RTI;
            DBGX_SELDR: t_next.tap = tms_i ? DBGX_SELIR : DBGX_CAPDR;
            DBGX_CAPDR: t_next.tap = tms_i ? DBGX_EX1DR : DBGX_SHDR;
            DBGX_SHDR: t_next.tap = tms_i ? DBGX_EX1DR : DBGX_SHDR;
            DBGX_EX1DR: t_next.tap = tms_i ? DBGX_UPDR : DBGX_PSDR;
            DBGX_PSDR: t_next.tap = tms_i ? DBGX_EX2DR : DBGX_PSDR;
            DBGX_EX2DR: t_next.tap = tms_i ? DBGX_UPDR : DBGX_SHDR;
            DBGX_UPDR: t_next.tap = tms_i ? DBGX_SELDR : DBGX_RTI;
            DBGX_SELIR: t_next.tap = tms_i ? DBGX_TLR : DBGX_CAPIR;
            DBGX_CAPIR: t_next.tap = tms_i ? DBGX_EX1IR : DBGX_SHIR;
            DBGX_SHIR: t_next.tap = tms_i ? DBGX_EX1IR : DBGX_SHIR;
            DBGX_EX1IR: t_next.tap = tms_i ? DBGX_UPIR : DBGX_PSIR;
            DBGX_PSIR: t_next.tap = tms_i ? DBGX_EX2IR : DBGX_PSIR;
            DBGX_EX2IR: t_next.tap = tms_i ? DBGX_UPIR : DBGX_SHIR;
            DBGX_UPIR: t_next.tap = tms_i ? DBGX_SELDR : DBGX_RTI;
            default: t_next.tap = DBGX_TLR;
        endcase
        case (t_reg.tap)
            DBGX_TLR: begin
                t_next.ir = `DBGX_IR_BYPASS;
            end
            DBGX_CAPDR: begin
                t_next.sr = {t_reg.brk_sync[1], t_reg.upd[31:0]}; // [R18]
            end
            DBGX_SHDR: begin
                t_next.sr = {t_reg.sr[`DBGX_CHAIN_LEN-2:0], tdi_i}; // [R11]
                t_next.tdo = t_reg.sr[`DBGX_CHAIN_LEN-1];
            end
            DBGX_UPDR: begin
                if (t_reg.ir == `DBGX_IR_INTEST) begin
                    t_next.upd = t_reg.sr;
                    t_next.ins_tgl = !t_reg.ins_tgl;
                    t_next.sysmode = 1'b0;
                end
            end
            DBGX_CAPIR: begin
                t_next.ir_sr = `DBGX_IR_CAPTURE;
            end
            DBGX_SHIR: begin
                t_next.ir_sr = {tdi_i, t_reg.ir_sr[`DBGX_IR_LEN-1:1]};
                t_next.tdo = t_reg.ir_sr[0];
            end
            DBGX_UPIR: begin
                t_next.ir = t_reg.ir_sr;
            end
            default: begin
                t_next.tdo = t_reg.tdo;
            end
        endcase
        if (t_next.tap == DBGX_RTI && t_reg.tap != DBGX_RTI
            && t_next.ir == `DBGX_IR_RESTART) begin // [R3]
            t_next.rst_tgl = !t_reg.rst_tgl;
            t_next.sysmode = 1'b1;
        end
    end

    always_ff @(posedge tck_i) begin
        if (link_rst_i) begin
            t_reg <= '{tap: DBGX_TLR, ir: `DBGX_IR_BYPASS, ir_sr: `DBGX_IR_CAPTURE,
                       sr: 33'h0, upd: 33'h0, ins_tgl: 1'b0,
                       rst_tgl: 1'b0, sysmode: 1'b1, brk_sync: 2'h0, tdo: 1'b0};
        end else begin
            t_reg <= t_next;
        end
    end

    assign tdo_o = t_reg.tdo;

endmodule // dbgx_core

// ==== tb/dbgx_chk.sv ====
/* Assertions on the ports of the debug-state block.
   Assumes the bench never raises a core event outside the state it is meant for. */
`timescale 1ns/1ps
module dbgx_chk (
    // Clock and reset.
    input wire logic ref_clk_i,
    input wire logic srst_i,
    // Core events.
    input wire logic external_halt_request_i,
    input wire logic breakpoint_hit_i,
    input wire logic watchpoint_hit_i,
    input wire logic exception_i,
    input wire logic exception_done_i,
    input wire logic sys_access_done_i,
    input wire logic sys_access_abort_i,
    input wire logic force_indicator_i,
    input wire logic [31:0] core_pc_i,
    // Status toward the system.
    input wire logic debug_state_indicator_o,
    input wire logic system_clock_qualifier_o,
    input wire logic mem_fetch_o,
    input wire logic pipeline_flush_o,
    input wire logic abort_mode_o,
    input wire logic scan_break_flag_o,
    input wire logic method_of_entry_bit_o,
    input wire logic [31:0] pc_o
);
    // ==========
    // Properties.
    wire logic ind = debug_state_indicator_o;
    // Qualified clock and no indicator: running, waiting on an exception or in a system step.
    wire logic run = system_clock_qualifier_o && !ind;
    default clocking cb @(posedge ref_clk_i); endclocking
    default disable iff (srst_i);
    property p_flush; pipeline_flush_o |-> ind ##1 !pipeline_flush_o; endproperty
    a_flush: assert property (p_flush) else $error("flush not a single pulse");
    property p_bp; breakpoint_hit_i && run |=> pipeline_flush_o && !scan_break_flag_o
        && !method_of_entry_bit_o && pc_o == $past(core_pc_i) + 32'h10; endproperty
    a_bp: assert property (p_bp) else $error("breakpoint entry wrong");
    property p_wp; watchpoint_hit_i && !exception_i && run |=> ind && scan_break_flag_o
        && !method_of_entry_bit_o && pc_o == $past(core_pc_i) + 32'h10; endproperty
    a_wp: assert property (p_wp) else $error("watchpoint entry wrong");
    property p_exc; exception_done_i && run |=> ind && pc_o == $past(core_pc_i) + 32'hc;
    endproperty
    a_exc: assert property (p_exc) else $error("exception entry wrong");
    property p_req; $rose(external_halt_request_i) && run |-> ##[2:4] (ind
        && method_of_entry_bit_o && pc_o == core_pc_i + 32'hc); endproperty
    a_req: assert property (p_req) else $error("request entry wrong");
    // The last normal access still runs in the cycle after the rise.
    property p_stop; $rose(ind) && !$past(force_indicator_i) |-> mem_fetch_o
        ##1 mem_fetch_o ##1 !mem_fetch_o; endproperty
    a_stop: assert property (p_stop) else $error("fetch did not stop");
    property p_go; $fell(ind) && !$past(force_indicator_i, 2) |-> !mem_fetch_o ##1 mem_fetch_o;
    endproperty
    a_go: assert property (p_go) else $error("fetch did not restart");
    property p_force; force_indicator_i && $past(force_indicator_i) |-> ind; endproperty
    a_force: assert property (p_force) else $error("indicator not forced");
    property p_sys; (sys_access_done_i || sys_access_abort_i) && run |=> ind
        && scan_break_flag_o && pc_o == $past(pc_o) + 32'hc; endproperty
    a_sys: assert property (p_sys) else $error("system access end wrong");
    property p_abort; sys_access_abort_i && run |=> abort_mode_o; endproperty
    a_abort: assert property (p_abort) else $error("abort mode missing");
    c_flush: cover property (pipeline_flush_o);
    c_resume: cover property ($fell(ind));
    c_abort: cover property (abort_mode_o);
endmodule // dbgx_chk
bind dbgx_core dbgx_chk u_chk (.*);

// ==== tb/dbgx_dbg.sv ====
/* Debugger model on the test port: link reset, instruction register and scan chain 1.
   Assumes the caller leaves the TAP in RUN-TEST/IDLE between frames. */
`timescale 1ns/1ps
module dbgx_dbg (
    // Test port toward the core.
    output logic tck_o,
    output logic rst_o,
    output logic tms_o,
    output logic tdi_o,
    // Serial data back from the core.
    input wire logic tdo_i
);
    // Chain contents shifted out by the last data frame.
    logic [32:0] cap;
    // ==========
    // Frames. The clock only runs inside them, as a real probe leaves it.
    initial begin
        tck_o = 1'b0;
        rst_o = 1'b1;
        tms_o = 1'b1;
        tdi_o = 1'b0;
    end
    task automatic tk(input logic m, input logic d);
        tms_o = m;
        tdi_o = d;
        #32 tck_o = 1'b1;
        #32 tck_o = 1'b0;
    endtask
    task automatic init();
        tk(1'b1, 1'b0);
        tk(1'b1, 1'b0);
        rst_o = 1'b0;
        tk(1'b0, 1'b0);
    endtask
    // Ends in UPDATE-IR, so the caller decides when idle is entered.
    task automatic ir(input logic [3:0] c);
        tk(1'b1, 1'b0);
        tk(1'b1, 1'b0);
        tk(1'b0, 1'b0);
        tk(1'b0, 1'b0);
        for (int i = 0; i < 4; i++) tk(i == 3, c[i]);
        tk(1'b1, 1'b0);
    endtask
    task automatic dr(input logic [32:0] v);
        tk(1'b1, 1'b0);
        tk(1'b0, 1'b0);
        tk(1'b0, 1'b0);
        for (int i = 32; i >= 0; i--) begin
            tk(i == 0, v[i]);
            cap[i] = tdo_i;
        end
        tk(1'b1, 1'b0);
        tk(1'b0, 1'b0);
    endtask
endmodule // dbgx_dbg

// ==== tb/tb_top.sv ====
/* Self-checking bench: core events on the system clock, debugger frames on the test clock.
   Assumes the checker is bound to the design. */
`timescale 1ns/1ps
`define CHK(a, b) begin comparisons++; if ((a) !== (b)) begin n_errors++; \
    $display("[ERR] %0t %h %h", $time, a, b); end end
module tb_top;
    logic ref_clk_i = 1'b0;
    logic srst_i = 1'b1;
    logic req = 1'b0;
    logic frc = 1'b0;
    logic [5:0] ev = 6'h0;
    logic [31:0] core_pc = 32'h0;
    logic tck, lrst, tms, tdi, tdo, ind, qual, abt, brk, moe;
    logic [31:0] pc;
    int n_errors = 0;
    int comparisons = 0;
    always #25 ref_clk_i = ~ref_clk_i;
    dbgx_dbg u_dbg (.tck_o(tck), .rst_o(lrst), .tms_o(tms), .tdi_o(tdi), .tdo_i(tdo));
    dbgx_core DUT (.ref_clk_i(ref_clk_i), .srst_i(srst_i), .tck_i(tck), .link_rst_i(lrst),
        .tms_i(tms), .tdi_i(tdi), .tdo_o(tdo), .core_pc_i(core_pc),
        .external_halt_request_i(req), .breakpoint_hit_i(ev[0]), .watchpoint_hit_i(ev[1]),
        .exception_i(ev[2]), .exception_done_i(ev[3]), .sys_access_done_i(ev[4]),
        .sys_access_abort_i(ev[5]), .force_indicator_i(frc), .debug_state_indicator_o(ind),
        .system_clock_qualifier_o(qual), .mem_fetch_o(), .pipeline_flush_o(),
        .abort_mode_o(abt), .scan_break_flag_o(brk), .method_of_entry_bit_o(moe), .pc_o(pc));
    // ==========
    // Helpers.
    task automatic w(input int n);
        repeat (n) @(posedge ref_clk_i);
        #1;
    endtask
    task automatic hit(input logic [5:0] v, input logic [31:0] p);
        @(posedge ref_clk_i);
        ev <= v;
        core_pc <= p;
        @(posedge ref_clk_i);
        ev <= 6'h0;
        w(4);
    endtask
    task automatic intest();
        u_dbg.ir(4'hc);
        u_dbg.tk(1'b0, 1'b0);
    endtask
    // Two fill instructions, the second armed, then the branch home.
    task automatic leave(input logic [31:0] cur, input logic [31:0] tgt, input logic b);
        logic [31:0] off;
        off = (tgt - cur - 32'hc) >> 2;
        intest();
        u_dbg.dr({1'b0, 32'he1a00000});
        `CHK(u_dbg.cap[32], b)
        u_dbg.dr({1'b1, 32'he5801000});
        `CHK(u_dbg.cap[31:0], 32'he1a00000)
        u_dbg.dr({1'b0, 8'hea, off[23:0]});
        u_dbg.ir(4'h4);
        w(8);
        `CHK(ind, 1'b1)
        u_dbg.tk(1'b0, 1'b0);
        for (int i = 0; i < 20 && ind !== 1'b0; i++) w(1);
        `CHK({ind, abt, pc}, {2'b00, tgt})
    endtask
    // ==========
    // Scenarios.
    task automatic t_bp();
        hit(6'h01, 32'h100);
        `CHK({ind, brk, moe, pc}, {3'b100, 32'h110})
        leave(32'h110, 32'h100, 1'b0);
    endtask
    task automatic t_wp();
        hit(6'h02, 32'h200);
        `CHK({ind, brk, moe, pc}, {3'b110, 32'h210})
        intest();
        u_dbg.dr({1'b1, 32'he5801000});
        u_dbg.dr({1'b0, 32'he5901000});
        u_dbg.ir(4'h4);
        u_dbg.tk(1'b0, 1'b0);
        w(8);
        `CHK({ind, qual}, 2'b01)
        hit(6'h20, 32'h200);
        `CHK({ind, abt, brk, pc}, {3'b111, 32'h220})
        leave(32'h220, 32'h200, 1'b1);
    endtask
    task automatic t_exc();
        hit(6'h06, 32'h300);
        `CHK(ind, 1'b0)
        hit(6'h08, 32'h300);
        `CHK({ind, brk, pc}, {2'b11, 32'h30c})
        leave(32'h30c, 32'h300, 1'b1);
    endtask
    task automatic t_req();
        @(posedge ref_clk_i);
        core_pc <= 32'h400;
        req <= 1'b1;
        w(6);
        `CHK({ind, moe, pc}, {2'b11, 32'h40c})
        @(posedge ref_clk_i);
        req <= 1'b0;
        leave(32'h40c, 32'h400, 1'b0);
    endtask
    task automatic t_force();
        @(posedge ref_clk_i);
        frc <= 1'b1;
        w(3);
        `CHK(ind, 1'b1)
        @(posedge ref_clk_i);
        frc <= 1'b0;
        w(3);
        `CHK(ind, 1'b0)
    endtask
    task automatic close_out();
        if (n_errors == 0 && comparisons > 0) $display("RESULT: PASS");
        else $display("RESULT: FAIL");
        $finish;
    endtask
    initial begin
        fork
            #1 u_dbg.init();
        join_none
        repeat (3) @(posedge ref_clk_i);
        srst_i <= 1'b0;
        w(4);
        t_bp();
        t_wp();
        t_exc();
        t_req();
        t_force();
        close_out();
    end
    // The whole run needs well under a fifth of this span.
    initial begin
        #3000000;
        n_errors++;
        close_out();
    end
endmodule // tb_top
